// File: design/sfi_top.sv
`timescale 1ns/1ps
module sfi_top #(
  parameter int unsigned PU_CYCLES = sfi_pkg::POWERUP_CYC
) (
  // system clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // supply monitors, asynchronous
  input  wire logic       vdd_off,
  input  wire logic       vdd_undervolt,
  // serial link pins
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic [3:0] io_i,
  input  wire logic       wp_n,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe,
  // volatile registers and options
  input  wire logic [7:0] status1_volatile,
  input  wire logic [7:0] config1_volatile,
  input  wire logic [7:0] config2_volatile,
  input  wire logic       hw_reset_en,
  input  wire logic       dlp_en,
  input  wire logic [3:0] out_nibble,
  // state and command report
  output sfi_pkg::sfi_state_type iface_state,
  output logic            deep_sleep,
  output logic            cmd_valid,
  output logic      [7:0] cmd_opcode,
  output logic            cmd_reject,
  output logic            wp_sample_n
);
  import sfi_pkg::*;

  localparam logic [CNT_W-1:0] PU_LAST = CNT_W'(PU_CYCLES - 1);

  typedef struct packed {
    logic       tog;
    logic [7:0] sh1;
    logic [7:0] sh4;
  } sfi_link_type;

  typedef struct packed {
    sfi_state_type    state;
    sfi_fmt_type      fmt;
    logic [5:0]       in_cyc;
    logic             has_lat;
    logic             is_read;
    logic [5:0]       phase_cnt;
    logic [2:0]       bits_mod;
    logic             cs_prev;
    logic             tog_prev;
    logic [7:0]       opcode;
    logic [CNT_W-1:0] timer;
    logic             dur_done;
    logic [CNT_W-1:0] rp_cnt;
    logic             deep_sleep;
    logic             cmd_valid;
    logic             cmd_reject;
    logic             wp_n;
    logic [3:0]       io_oe;
    logic [3:0]       io_o;
  } sfi_ref_type;

  sfi_link_type lk_ff;
  sfi_link_type nxt_lk;
  sfi_ref_type  st_ff;
  sfi_ref_type  nxt_st;

  logic [5:0] sync_q;
  logic       cs_s;
  logic       io3_s;
  logic       wp_s;
  logic       off_s;
  logic       uv_s;
  logic       tog_s;
  logic       quad_protocol_mode;
  logic       quad_on;
  logic       busy;
  logic       sck_edge;
  logic       frame;
  logic       rst_ok;
  logic       rst_hit;
  logic [2:0] bpe;
  logic [5:0] instr_edges;
  logic [5:0] lat;

  // link side: shift on every rising sck, cleared while select is high
  always_comb begin
    nxt_lk     = lk_ff;
    nxt_lk.tog = ~lk_ff.tog;
    nxt_lk.sh1 = {lk_ff.sh1[6:0], io_i[0]};
    nxt_lk.sh4 = {lk_ff.sh4[3:0], io_i};
  end

  // an aligned frame has an even edge count, so the toggle is already
  // low when select clears it and no false edge is seen
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      lk_ff <= '0;
    end else begin
      lk_ff <= nxt_lk;
    end
  end

  // pins and the link toggle into the ref_clk domain
  sfi_sync #(
    .WIDTH (6),
    .INIT  (SYNC_INIT)
  ) u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .d_async ({cs_n, io_i[3], wp_n, vdd_off, vdd_undervolt, lk_ff.tog}),
    .q_sync  (sync_q)
  );

  assign {cs_s, io3_s, wp_s, off_s, uv_s, tog_s} = sync_q;

  // configuration decode
  assign quad_protocol_mode     = config2_volatile[CR2_QPI_BIT];
  assign quad_on = config1_volatile[CR1_QUAD_BIT] | quad_protocol_mode;
  assign busy    = status1_volatile[SR1_BUSY_BIT];
  assign lat     = {2'h0, config2_volatile[CR2_LAT_MSB:0]};
  assign bpe     = quad_protocol_mode ? BPE_QPI : BPE_SPI;
  assign instr_edges = quad_protocol_mode ? INSTR_EDGES_QPI : INSTR_EDGES_SPI;

  // one rising sck seen per toggle change, only while select is low
  assign sck_edge = !cs_s && (tog_s != st_ff.tog_prev);
  assign frame = (st_ff.state == ST_INSTR) || (st_ff.state == ST_INPUT) ||
                 (st_ff.state == ST_LATENCY) || (st_ff.state == ST_OUTPUT);

  // io3 acts as reset only when it is not carrying quad data
  assign rst_ok = hw_reset_en && (!quad_on || cs_s) &&
                  (st_ff.state != ST_OFF) && (st_ff.state != ST_UVLO) &&
                  (st_ff.state != ST_POR) && (st_ff.state != ST_HWRST);
  assign rst_hit = rst_ok && !io3_s && (st_ff.rp_cnt == RP_LAST);

  // interface state machine
  always_comb begin
    logic [7:0]  op;
    sfi_dec_type dec;
    // the shift words are stable for a whole sck period after the edge
    // whose toggle is being seen, so reading them here is safe
    op  = quad_protocol_mode ? lk_ff.sh4 : lk_ff.sh1;
    dec = sfi_decode(op, quad_protocol_mode);
    nxt_st            = st_ff;
    nxt_st.cs_prev    = cs_s;
    nxt_st.tog_prev   = tog_s;
    nxt_st.cmd_valid  = 1'b0;
    nxt_st.cmd_reject = 1'b0;
    nxt_st.io_o       = out_nibble;
    // count how long io3 has been low
    if (rst_ok && !io3_s) begin
      if (st_ff.rp_cnt != RP_LAST) begin
        nxt_st.rp_cnt = st_ff.rp_cnt + 1'b1;
      end
    end else begin
      nxt_st.rp_cnt = '0;
    end
    case (st_ff.state)
      ST_OFF: begin
        nxt_st.state = ST_POR;
        nxt_st.timer = '0;
      end
      ST_POR: begin
        // inputs ignored, nothing driven
        if (st_ff.timer == PU_LAST) begin
          nxt_st.state = ST_STANDBY;
        end else begin
          nxt_st.timer = st_ff.timer + 1'b1;
        end
      end
      ST_UVLO: begin
        if (!uv_s) begin
          nxt_st.state = ST_STANDBY;
        end
      end
      ST_HWRST: begin
        if (!st_ff.dur_done) begin
          if (st_ff.timer == DUR_LAST) begin
            nxt_st.dur_done = 1'b1;
            nxt_st.timer    = '0;
          end else begin
            nxt_st.timer = st_ff.timer + 1'b1;
          end
        end else if (!io3_s) begin
          nxt_st.timer = '0;
        end else if (st_ff.timer == HOLD_LAST) begin
          nxt_st.state = ST_STANDBY;
        end else begin
          nxt_st.timer = st_ff.timer + 1'b1;
        end
      end
      ST_WAKE: begin
        if (st_ff.timer == WAKE_LAST) begin
          nxt_st.state      = ST_STANDBY;
          nxt_st.deep_sleep = 1'b0;
        end else begin
          nxt_st.timer = st_ff.timer + 1'b1;
        end
      end
      ST_STANDBY: begin
        // select high: only the reset pin and the supply monitors are watched
        if (uv_s) begin
          nxt_st.state = ST_UVLO;
        end else if (!cs_s && st_ff.cs_prev) begin
          nxt_st.state     = ST_INSTR;
          nxt_st.phase_cnt = '0;
          nxt_st.bits_mod  = '0;
        end
      end
      ST_INSTR: begin
        if (sck_edge) begin
          nxt_st.bits_mod  = st_ff.bits_mod + bpe;
          nxt_st.phase_cnt = st_ff.phase_cnt + 1'b1;
          if (nxt_st.phase_cnt == instr_edges) begin
            nxt_st.opcode    = op;
            nxt_st.fmt       = dec.fmt;
            nxt_st.in_cyc    = dec.in_cyc;
            nxt_st.has_lat   = dec.has_lat;
            nxt_st.is_read   = dec.is_read && !st_ff.deep_sleep;
            nxt_st.phase_cnt = '0;
            nxt_st.state     = ST_INPUT;
            if (op == OP_WRITE_REGS || op == OP_WRITE_ANY) begin
              nxt_st.wp_n = wp_s;
            end
          end
        end
      end
      ST_INPUT: begin
        // address, mode or write data; reads leave after in_cyc edges
        if (sck_edge) begin
          nxt_st.bits_mod = st_ff.bits_mod + bpe;
          if (st_ff.is_read) begin
            nxt_st.phase_cnt = st_ff.phase_cnt + 1'b1;
            if (nxt_st.phase_cnt == st_ff.in_cyc) begin
              nxt_st.phase_cnt = '0;
              if (st_ff.has_lat && lat != 6'h00) begin
                nxt_st.state = ST_LATENCY;
              end else begin
                nxt_st.state = ST_OUTPUT;
              end
            end
          end
        end
      end
      ST_LATENCY: begin
        if (sck_edge) begin
          nxt_st.phase_cnt = st_ff.phase_cnt + 1'b1;
          if (nxt_st.phase_cnt == lat) begin
            nxt_st.state = ST_OUTPUT;
          end
        end
      end
      ST_OUTPUT: begin
        // stays until select rises, whatever the transfer count
        nxt_st.state = ST_OUTPUT;
      end
      default: begin
        nxt_st.state = ST_OFF;
      end
    endcase
    // select rising ends any command; non-read commands execute here
    if (frame && cs_s) begin
      nxt_st.state = ST_STANDBY;
      if (st_ff.state == ST_INPUT && !st_ff.is_read) begin
        if (st_ff.bits_mod != 3'h0 || uv_s) begin
          nxt_st.cmd_reject = 1'b1;
        end else if (st_ff.deep_sleep) begin
          if (st_ff.opcode == OP_WAKE) begin
            nxt_st.state     = ST_WAKE;
            nxt_st.timer     = '0;
            nxt_st.cmd_valid = 1'b1;
          end else begin
            nxt_st.cmd_reject = 1'b1;
          end
        end else if (st_ff.opcode == OP_DEEP_SLEEP) begin
          if (busy) begin
            nxt_st.cmd_reject = 1'b1;
          end else begin
            nxt_st.deep_sleep = 1'b1;
            nxt_st.cmd_valid  = 1'b1;
          end
        end else begin
          nxt_st.cmd_valid = 1'b1;
        end
      end
    end
    // reset pin overrides command states
    if (rst_hit) begin
      nxt_st.state      = ST_HWRST;
      nxt_st.timer      = '0;
      nxt_st.dur_done   = 1'b0;
      nxt_st.deep_sleep = 1'b0;
      nxt_st.cmd_valid  = 1'b0;
      nxt_st.cmd_reject = 1'b0;
    end
    // supply gone: everything restarts through power-on reset
    if (off_s) begin
      nxt_st.state      = ST_OFF;
      nxt_st.timer      = '0;
      nxt_st.deep_sleep = 1'b0;
      nxt_st.cmd_valid  = 1'b0;
      nxt_st.cmd_reject = 1'b0;
    end
    // drivers follow the next state so they switch with it
    nxt_st.io_oe = 4'h0;
    if (nxt_st.state == ST_OUTPUT) begin
      case (nxt_st.fmt)
        FMT_SINGLE: nxt_st.io_oe = 4'h2;
        FMT_DUAL:   nxt_st.io_oe = 4'h3;
        default:    nxt_st.io_oe = 4'hf;
      endcase
    end else if (nxt_st.state == ST_LATENCY && nxt_st.fmt == FMT_DDR &&
                 dlp_en && (lat - nxt_st.phase_cnt) <= DLP_CYC) begin
      nxt_st.io_oe = 4'hf;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_ff         <= '0;
      st_ff.state   <= ST_OFF;
      st_ff.fmt     <= FMT_SINGLE;
      st_ff.cs_prev <= 1'b1;
      st_ff.wp_n    <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // all outputs straight from the state register
  assign iface_state = st_ff.state;
  assign deep_sleep  = st_ff.deep_sleep;
  assign cmd_valid   = st_ff.cmd_valid;
  assign cmd_opcode  = st_ff.opcode;
  assign cmd_reject  = st_ff.cmd_reject;
  assign wp_sample_n = st_ff.wp_n;
  assign io_oe       = st_ff.io_oe;
  assign io_o        = st_ff.io_o;

  // checks on the ref_clk side
  a_oe_only_out: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (io_oe != 4'h0) |->
      (iface_state == ST_OUTPUT || iface_state == ST_LATENCY))
    else $error("data lines driven outside output or latency");

  a_por_quiet: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (iface_state == ST_POR) |-> (io_oe == 4'h0 && !cmd_valid))
    else $error("activity during power-on reset");

  a_uvlo_no_cmd: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    uv_s |=> !cmd_valid)
    else $error("command executed under low supply");

  a_cs_rise_idle: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (frame && cs_s && !rst_hit && !off_s) |=>
      ((iface_state == ST_STANDBY || iface_state == ST_WAKE) &&
       io_oe == 4'h0))
    else $error("select rise did not end the command");

  a_cs_fall_instr: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (iface_state == ST_STANDBY && !cs_s && st_ff.cs_prev && !uv_s &&
     !rst_hit && !off_s) |=> (iface_state == ST_INSTR))
    else $error("select fall did not start an instruction");

  a_sleep_not_busy: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(deep_sleep) |-> !$past(busy))
    else $error("deep sleep entered while busy");

  a_sleep_only_wake: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (cmd_valid && $past(deep_sleep)) |-> (cmd_opcode == OP_WAKE))
    else $error("command other than wake ran in deep sleep");

  a_wake_hold: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(iface_state == ST_WAKE) |->
      (iface_state == ST_WAKE || iface_state == ST_OFF ||
       iface_state == ST_HWRST)[*8])
    else $error("wake delay cut short");

  a_align_exec: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    cmd_valid |-> ($past(st_ff.bits_mod) == 3'h0))
    else $error("misaligned command executed");

  a_rst_entry: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (rst_hit && !off_s) |=> (iface_state == ST_HWRST))
    else $error("reset pulse did not start reset");

  a_out_hold: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (iface_state == ST_OUTPUT && !cs_s && !rst_hit && !off_s) |=>
      (iface_state == ST_OUTPUT))
    else $error("output phase left while selected");

  a_wp_instr: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $changed(wp_sample_n) |-> ($past(iface_state) == ST_INSTR))
    else $error("write-protect sampled outside instruction");

endmodule

// File: shared/sfi_pkg.sv
package sfi_pkg;
  localparam int CLK_MHZ = 100;
  // timing in ns; plain defaults, tune per part
  localparam int POWERUP_NS      = 300000;
  localparam int RESET_PULSE_NS  = 200;
  localparam int RESET_DUR_NS    = 35000;
  localparam int RELEASE_HOLD_NS = 50;
  localparam int WAKE_NS         = 3000;
  // least times rounded up to whole cycles
  localparam int POWERUP_CYC = (POWERUP_NS * CLK_MHZ + 999) / 1000;
  localparam int RP_CYC      = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int DUR_CYC     = (RESET_DUR_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC    = (RELEASE_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_CYC    = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] RP_LAST   = CNT_W'(RP_CYC - 1);
  localparam logic [CNT_W-1:0] DUR_LAST  = CNT_W'(DUR_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYC - 1);
  // instruction codes
  localparam logic [7:0] OP_DEEP_SLEEP  = 8'hb9;
  localparam logic [7:0] OP_WAKE        = 8'hab;
  localparam logic [7:0] OP_WRITE_REGS  = 8'h01;
  localparam logic [7:0] OP_WRITE_ANY   = 8'h71;
  localparam logic [7:0] OP_READ        = 8'h03;
  localparam logic [7:0] OP_FAST_READ   = 8'h0b;
  localparam logic [7:0] OP_DUAL_IO     = 8'hbb;
  localparam logic [7:0] OP_QUAD_IO     = 8'heb;
  localparam logic [7:0] OP_DDR_QUAD_IO = 8'hed;
  // register field positions
  localparam int SR1_BUSY_BIT = 0;
  localparam int CR1_QUAD_BIT = 1;
  localparam int CR2_QPI_BIT  = 6;
  localparam int CR2_LAT_MSB  = 3;
  // rising edges per phase, and bits shifted per edge
  localparam logic [5:0] INSTR_EDGES_SPI = 6'h08;
  localparam logic [5:0] INSTR_EDGES_QPI = 6'h02;
  localparam logic [5:0] CYC_SINGLE_IN   = 6'h18;
  localparam logic [5:0] CYC_DUAL_IN     = 6'h10;
  localparam logic [5:0] CYC_QUAD_IN     = 6'h08;
  localparam logic [5:0] CYC_DDR_IN      = 6'h04;
  localparam logic [5:0] DLP_CYC         = 6'h04;
  localparam logic [2:0] BPE_SPI = 3'h1;
  localparam logic [2:0] BPE_QPI = 3'h4;
  // pin synchroniser reset: select, io3, wp high
  localparam logic [5:0] SYNC_INIT = 6'h38;
  typedef enum logic [9:0] {
    ST_OFF     = 10'h001,
    ST_UVLO    = 10'h002,
    ST_POR     = 10'h004,
    ST_HWRST   = 10'h008,
    ST_STANDBY = 10'h010,
    ST_INSTR   = 10'h020,
    ST_INPUT   = 10'h040,
    ST_LATENCY = 10'h080,
    ST_OUTPUT  = 10'h100,
    ST_WAKE    = 10'h200
  } sfi_state_type;
  typedef enum logic [3:0] {
    FMT_SINGLE = 4'h1,
    FMT_DUAL   = 4'h2,
    FMT_QUAD   = 4'h4,
    FMT_DDR    = 4'h8
  } sfi_fmt_type;
  typedef struct packed {
    sfi_fmt_type fmt;
    logic [5:0]  in_cyc;
    logic        has_lat;
    logic        is_read;
  } sfi_dec_type;
  // instruction to format and input phase length
  function automatic sfi_dec_type sfi_decode(input logic [7:0] op,
                                             input logic       quad_protocol_mode);
    sfi_dec_type d;
    d = '{fmt: FMT_SINGLE, in_cyc: 6'h00, has_lat: 1'b0, is_read: 1'b0};
    if (op == OP_READ) begin
      d.is_read = 1'b1;
      d.in_cyc  = CYC_SINGLE_IN;
    end else if (op == OP_FAST_READ) begin
      d = '{fmt: FMT_SINGLE, in_cyc: CYC_SINGLE_IN, has_lat: 1'b1,
            is_read: 1'b1};
    end else if (op == OP_DUAL_IO) begin
      d = '{fmt: FMT_DUAL, in_cyc: CYC_DUAL_IN, has_lat: 1'b1,
            is_read: 1'b1};
    end else if (op == OP_QUAD_IO) begin
      d = '{fmt: FMT_QUAD, in_cyc: CYC_QUAD_IN, has_lat: 1'b1,
            is_read: 1'b1};
    end else if (op == OP_DDR_QUAD_IO) begin
      d = '{fmt: FMT_DDR, in_cyc: CYC_DDR_IN, has_lat: 1'b1,
            is_read: 1'b1};
    end
    // quad protocol moves every phase onto four lines
    if (quad_protocol_mode && d.fmt != FMT_DDR) begin
      d.fmt    = FMT_QUAD;
      d.in_cyc = CYC_QUAD_IN;
    end
    return d;
  endfunction
endpackage

// File: design/sfi_sync.sv
`timescale 1ns/1ps
module sfi_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // asynchronous in, synchronised out
  input  wire logic [WIDTH-1:0] d_async,
  output logic      [WIDTH-1:0] q_sync
);
  import sfi_pkg::*;
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sfi_sync_type;
  sfi_sync_type st_ff;
  sfi_sync_type nxt_st;
  // meta stage feeds only the second stage
  always_comb begin
    nxt_st.meta = d_async;
    nxt_st.sync = st_ff.meta;
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_ff <= {INIT, INIT};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign q_sync = st_ff.sync;
endmodule

// File: testbench/sfi_host.sv
`timescale 1ns/1ps
module sfi_host (
  // link pins toward the device
  output logic       sck,
  output logic       cs_n,
  output logic [3:0] io,
  output logic [3:0] hoe
);
  // idle: clock parked low, reset line held high
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    io = 4'hf;
    hoe = 4'h8;
  end
  // one frame; lines let go after d edges, keep leaves select low
  task automatic frame(input logic [7:0] op, input int e, input bit q,
                       input int d, input bit keep);
    logic [7:0] sh;
    sh = op;
    #13.7 cs_n = 1'b0;
    for (int i = 0; i < e; i++) begin
      hoe = i < d ? 4'hf : {~q, 3'h0};
      io = q ? sh[7:4] : {1'b1, ~io[2:1], sh[7]};
      sh = q ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
      #40 sck = 1'b1;
      #40 sck = 1'b0;
    end
    #40;
    if (!keep) deselect();
  endtask
  // end of frame; inverted levels so a stale bit never reads as data
  task automatic deselect();
    cs_n = 1'b1;
    io = {1'b1, ~io[2:0]};
    hoe = 4'h8;
  endtask
  // warm reset request on the reset line
  task automatic reset_pulse(input int ns);
    io[3] = 1'b0;
    #ns io[3] = 1'b1;
  endtask
endmodule

// File: testbench/sfi_top_bench.sv
`timescale 1ns/1ps
module sfi_top_bench;
  import sfi_pkg::*;
  localparam int PU = 20;
  // design pins; the inputs are all given a level at time zero
  logic ref_clk = 1'b0, sys_rst = 1'b1, vdd_off = 1'b0, wp_n = 1'b1;
  logic vdd_undervolt = 1'b0, hw_reset_en = 1'b0, dlp_en = 1'b0;
  logic [7:0] status1_volatile = 8'h00, config2_volatile = 8'h00;
  logic [7:0] config1_volatile = 8'h00, cmd_opcode;
  logic [3:0] out_nibble = 4'h0, flt = 4'h5, io_i, io_o, io_oe, hio, hoe;
  logic sck, cs_n, deep_sleep, cmd_valid, cmd_reject, wp_sample_n;
  sfi_state_type iface_state;
  // counters and model state
  int n_fail = 0, tests_run = 0, nv = 0, nr = 0, cyc = 0;
  int seed = 32'h2424;
  bit sleep_m = 0, uv = 0;
  sfi_top #(.PU_CYCLES(PU)) dut (.ref_clk, .sys_rst, .vdd_off,
    .vdd_undervolt, .sck, .cs_n, .io_i, .wp_n, .io_o, .io_oe,
    .status1_volatile, .config1_volatile, .config2_volatile,
    .hw_reset_en, .dlp_en, .out_nibble, .iface_state, .deep_sleep,
    .cmd_valid, .cmd_opcode, .cmd_reject, .wp_sample_n);
  sfi_host host (.sck, .cs_n, .io(hio), .hoe);
  // wire level: device, else host, else a pattern changing each cycle
  assign io_i = io_oe & io_o | ~io_oe & (hoe & hio | ~hoe & flt);
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // pulse counts, drive watch and hang guard
  always @(posedge ref_clk) begin
    flt <= ~flt;
    cyc++;
    if (cmd_valid === 1'b1) nv++;
    if (cmd_reject === 1'b1) nr++;
    // ddr latency may drive the learning pattern when it is enabled
    if (!sys_rst && io_oe !== 4'h0) chk(iface_state == ST_OUTPUT ||
      (dlp_en && iface_state == ST_LATENCY), 1'b1);
    if (cyc == 40000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic at(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // bounded wait for a state
  task automatic wait_state(input sfi_state_type s, input int lim);
    for (int i = 0; i < lim && iface_state !== s; i++) at(1);
    chk(iface_state, s);
  endtask
  // 0 nothing, 1 executed, 2 rejected
  function automatic int model(input int op, input int bits);
    if (uv) return 0;
    if (bits % 8 != 0) return 2;
    if (sleep_m && op != 'hab) return 2;
    if (op == 'hb9 && status1_volatile[0]) return 2;
    return 1;
  endfunction
  task automatic run(input logic [7:0] op, input int e, input bit q = 0);
    int v0, r0, m;
    v0 = nv;
    r0 = nr;
    m = model(op, e * (q ? 4 : 1));
    host.frame(op, e, q, e, 1'b0);
    at(10);
    chk(nv - v0, m == 1);
    if (uv) return;
    chk(nr - r0, m == 2);
    chk(cmd_opcode, op);
    if (m == 1 && op == OP_DEEP_SLEEP) sleep_m = 1;
    if (op != OP_WAKE) chk(deep_sleep, sleep_m);
    chk(iface_state, sleep_m && op == OP_WAKE ? ST_WAKE : ST_STANDBY);
  endtask
  // read left open: data must flow until select rises
  task automatic rd(input logic [7:0] op, input int n, input int lat,
                    input logic [3:0] oe);
    int v0;
    v0 = nv + nr;
    config2_volatile = 8'(lat);
    host.frame(op, 9 + n + lat, 1'b0, 8 + n, 1'b1);
    at(8);
    chk(iface_state, ST_OUTPUT);
    chk(io_oe, oe);
    chk(io_o, out_nibble);
    host.deselect();
    at(8);
    chk({io_oe, iface_state}, {4'h0, ST_STANDBY});
    chk(nv + nr, v0);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    at(16);
    sys_rst = 1'b0;
    wait_state(ST_POR, 6);
    at(PU - 4);
    chk(iface_state, ST_POR);
    wait_state(ST_STANDBY, 8);
    $display("test power-up done");
    repeat (4) run(8'h20 | 8'($random(seed) & 15), 8);
    repeat (4) run(8'h20, 9 + ($random(seed) & 6));
    $display("test framing done");
    status1_volatile = 8'($random(seed)) | 8'h01;
    run(OP_WAKE, 8);
    run(OP_DEEP_SLEEP, 8);
    status1_volatile[0] = 1'b0;
    run(OP_DEEP_SLEEP, 8);
    run(8'h20, 8);
    run(OP_WAKE, 8);
    at(WAKE_CYC - 30);
    chk(iface_state, ST_WAKE);
    wait_state(ST_STANDBY, 40);
    sleep_m = 0;
    chk(deep_sleep, 1'b0);
    $display("test deep sleep done");
    wp_n = 1'b0;
    run(OP_WRITE_REGS, 8);
    chk(wp_sample_n, 1'b0);
    wp_n = 1'b1;
    run(8'h20, 8);
    chk(wp_sample_n, 1'b0);
    run(OP_WRITE_ANY, 8);
    chk(wp_sample_n, 1'b1);
    $display("test write protect done");
    config2_volatile = 8'h40;
    run(8'h20 | 8'($random(seed) & 15), 2, 1'b1);
    run(8'h2a, 3, 1'b1);
    out_nibble = 4'($random(seed));
    rd(OP_FAST_READ, 24, 8, 4'h2);
    rd(OP_DUAL_IO, 16, 0, 4'h3);
    rd(OP_QUAD_IO, 8, 3, 4'hf);
    // ddr read with the learning pattern in its last latency cycles
    dlp_en = 1'b1;
    rd(OP_DDR_QUAD_IO, 4, 6, 4'hf);
    $display("test quad and reads done");
    uv = 1;
    vdd_undervolt = 1'b1;
    run(8'h21, 8);
    uv = 0;
    vdd_undervolt = 1'b0;
    wait_state(ST_STANDBY, 40);
    run(8'h22, 8);
    host.reset_pulse(300);
    at(40);
    chk(iface_state, ST_STANDBY);
    hw_reset_en = 1'b1;
    host.reset_pulse(150);
    at(40);
    chk(iface_state, ST_STANDBY);
    host.reset_pulse(300);
    at(2);
    chk(iface_state, ST_HWRST);
    at(DUR_CYC - 100);
    chk(iface_state, ST_HWRST);
    wait_state(ST_STANDBY, 200);
    $display("test undervolt and reset done");
    vdd_off = 1'b1;
    at(6);
    chk(iface_state, ST_OFF);
    vdd_off = 1'b0;
    wait_state(ST_POR, 6);
    wait_state(ST_STANDBY, PU + 6);
    $display("test supply done");
    print_verdict();
  end
endmodule
